// ===== rwdt_pkg.sv
package rwdt_pkg;
  // register offsets (printed offsets are not multiples of four: they are indices)
  localparam logic [15:0] MODE_IDX = 16'h0300;
  localparam logic [15:0] CMD_IDX = 16'h0301;
  localparam logic [15:0] IRQ_STAT_IDX = 16'h0302;
  localparam logic [15:0] IRQ_MASK_IDX = 16'h0303;
  localparam logic [15:0] STATUS_IDX = 16'h0304;
  localparam int ADDR_W = 18;
  localparam logic [17:0] MODE_ADDR = {MODE_IDX, 2'b00};
  localparam logic [17:0] CMD_ADDR = {CMD_IDX, 2'b00};
  localparam logic [17:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX, 2'b00};
  localparam logic [17:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
  localparam logic [17:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  // mode register fields
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_PSEL_HI = 6;
  localparam int MODE_PSEL_LO = 5;
  localparam int MODE_I2_BIT = 2;
  localparam int MODE_RC_BIT = 1;
  localparam logic [7:0] MODE_WMASK = 8'hE6;
  localparam logic [7:0] MODE_RST = 8'h80;
  // command keys
  localparam logic [7:0] KEY_DISABLE = 8'hB1;
  localparam logic [7:0] KEY_CLEAR = 8'h4E;
  // counter
  localparam int CNT_W = 22;
  localparam int TAP0 = 15;
  localparam int TAP1 = 17;
  localparam int TAP2 = 19;
  localparam int TAP3 = 21;
  // internal reset pulse, in states (one state = one system clock cycle)
  localparam int RST_STATES = 22;
  localparam logic [4:0] RST_LEN = 5'(RST_STATES);
  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_RST = 1;
  localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
  typedef enum logic [1:0] {
    RWDT_ST_RUN = 2'b00,
    RWDT_ST_OFF = 2'b01,
    RWDT_ST_RST = 2'b10
  } rwdt_state_t;
  function automatic logic [CNT_W-1:0] rwdt_tap_mask(input logic [1:0] sel);
    case (sel)
      2'b00: rwdt_tap_mask = CNT_W'(1) << TAP0;
      2'b01: rwdt_tap_mask = CNT_W'(1) << TAP1;
      2'b10: rwdt_tap_mask = CNT_W'(1) << TAP2;
      default: rwdt_tap_mask = CNT_W'(1) << TAP3;
    endcase
  endfunction : rwdt_tap_mask
endpackage : rwdt_pkg

// ===== rwdt_counter.sv
`timescale 1ns/1ps
module rwdt_counter
  import rwdt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic clear,
  input wire logic [1:0] period_select,
  output logic overflow,
  output logic [rwdt_pkg::CNT_W-1:0] count
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] tap;
  logic ovf_nxt;
  logic ovf_r;

  always_comb begin
    tap = rwdt_tap_mask(period_select);
    cnt_nxt = cnt_r;
    ovf_nxt = 1'b0;
    if (clear) begin
      cnt_nxt = '0;
    end else if (run) begin
      // overflow after exactly tap running cycles from a clear
      if (((cnt_r + CNT_W'(1)) & (tap - CNT_W'(1))) == '0) begin
        ovf_nxt = 1'b1;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      ovf_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign overflow = ovf_r;
  assign count = cnt_r;
endmodule : rwdt_counter

// ===== rwdt_runaway_watchdog.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module rwdt_runaway_watchdog
  import rwdt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rwdt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_one_mode,
  input wire logic idle_two_mode,
  input wire logic stop_mode,
  output logic watchdog_overflow_irq,
  output logic internal_reset_req,
  output logic irq
);
  rwdt_state_t st_r;
  rwdt_state_t st_nxt;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] stat_nxt;
  logic [IRQ_W-1:0] mask_r;
  logic [IRQ_W-1:0] mask_nxt;
  logic [4:0] rcnt_r;
  logic [4:0] rcnt_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic nmi_r;
  logic nmi_nxt;
  logic rstreq_r;
  logic rstreq_nxt;
  logic irq_r;
  logic irq_nxt;
  // one-hot register selects; a new register needs an entry here and in the decode
  localparam int SEL_W = 5;
  localparam int SEL_MODE = 0;
  localparam int SEL_CMD = 1;
  localparam int SEL_STAT = 2;
  localparam int SEL_MASK = 3;
  localparam int SEL_STATUS = 4;

  logic access;
  logic wr;
  logic rd;
  logic hit;
  logic cnt_run;
  logic cnt_clear;
  logic ovf;
  logic [CNT_W-1:0] count;
  logic key_clear;
  logic key_disable;
  logic [SEL_W-1:0] sel;
  logic [SEL_W-1:0] wr_sel;
  logic [SEL_W-1:0] rd_sel;
  logic stat_clear;
  logic rst_start;
  logic [IRQ_W-1:0] irq_event;
  logic [31:0] rd_word;

  // shared by the error flag, the writes, the read-clear and the keys
  function automatic logic [SEL_W-1:0] reg_select(input logic [ADDR_W-1:0] addr);
    logic [SEL_W-1:0] onehot;
    onehot = '0;
    case (addr)
      MODE_ADDR: onehot[SEL_MODE] = 1'b1;
      CMD_ADDR: onehot[SEL_CMD] = 1'b1;
      IRQ_STAT_ADDR: onehot[SEL_STAT] = 1'b1;
      IRQ_MASK_ADDR: onehot[SEL_MASK] = 1'b1;
      STATUS_ADDR: onehot[SEL_STATUS] = 1'b1;
      default: onehot = '0;
    endcase
    return onehot;
  endfunction : reg_select

  // only the full byte counts; a near miss from runaway code must do nothing
  function automatic logic is_key(input logic [31:0] data, input logic [7:0] key);
    return data[7:0] == key;
  endfunction : is_key

  // one wait state: pready is registered from the first access cycle
  assign access = psel && penable && !pready_r;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign sel = reg_select(paddr);
  assign wr_sel = wr ? sel : '0;
  assign rd_sel = rd ? sel : '0;
  assign hit = |sel;

  // only the exact keys act; any other byte is ignored
  assign key_clear = wr_sel[SEL_CMD] && is_key(pwdata, KEY_CLEAR);
  assign key_disable = wr_sel[SEL_CMD] && is_key(pwdata, KEY_DISABLE);

  // a read of the status word clears it after this access
  assign stat_clear = rd_sel[SEL_STAT];

  // the reset cause bit marks only the first cycle of a watchdog reset
  assign rst_start = rstreq_nxt && !rstreq_r;
  assign irq_event[IRQ_OVF] = ovf;
  assign irq_event[IRQ_RST] = rst_start;

  // low-power gating: idle-1 and stop freeze, idle-2 follows its bit
  assign cnt_run = (st_r == RWDT_ST_RUN) && !idle_one_mode && !stop_mode
                   && (!idle_two_mode || mode_r[MODE_I2_BIT]);
  // pclk is the system clock; the gear/2 division sits upstream
  assign cnt_clear = key_clear || (st_r != RWDT_ST_RUN);

  rwdt_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .run(cnt_run),
    .clear(cnt_clear),
    .period_select(mode_r[MODE_PSEL_HI:MODE_PSEL_LO]),
    .overflow(ovf),
    .count(count)
  );

  always_comb begin
    st_nxt = st_r;
    rcnt_nxt = rcnt_r;
    rstreq_nxt = 1'b0;
    case (st_r)
      RWDT_ST_RUN: begin
        // disable needs the enable bit already clear when the key lands
        if (key_disable && !mode_r[MODE_EN_BIT]) begin
          st_nxt = RWDT_ST_OFF;
        end else if (ovf && mode_r[MODE_RC_BIT]) begin
          st_nxt = RWDT_ST_RST;
          rcnt_nxt = RST_LEN;
          rstreq_nxt = 1'b1;
        end
      end
      RWDT_ST_OFF: begin
        if (mode_r[MODE_EN_BIT]) begin
          st_nxt = RWDT_ST_RUN;
        end
      end
      RWDT_ST_RST: begin
        // fixed 22-state pulse, inside the allowed 22..29 window
        if (rcnt_r == 5'h01) begin
          st_nxt = RWDT_ST_RUN;
          rcnt_nxt = 5'h00;
        end else begin
          rcnt_nxt = rcnt_r - 5'h01;
          rstreq_nxt = 1'b1;
        end
      end
      default: begin
        st_nxt = RWDT_ST_RUN;
        rcnt_nxt = 5'h00;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= RWDT_ST_RUN;
      rcnt_r <= 5'h00;
      rstreq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      rcnt_r <= rcnt_nxt;
      rstreq_r <= rstreq_nxt;
    end
  end

  // mode register: unused bits are dropped so they always read zero
  always_comb begin
    mode_nxt = mode_r;
    if (wr_sel[SEL_MODE]) begin
      mode_nxt = pwdata[7:0] & MODE_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_RST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // interrupt mask: gates only the summary line
  always_comb begin
    mask_nxt = mask_r;
    if (wr_sel[SEL_MASK]) begin
      mask_nxt = pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= '0;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // sticky status: an event in the cycle of the read-clear wins, so none is lost
  genvar gi;
  for (gi = 0; gi < IRQ_W; gi++) begin : g_stat
    assign stat_nxt[gi] = irq_event[gi] || (stat_r[gi] && !stat_clear);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // read data: captured in the access cycle, stands with pready
  always_comb begin
    rd_word = BAD_ADDR_DATA;
    case (paddr)
      MODE_ADDR: rd_word = {24'h000000, mode_r};
      IRQ_STAT_ADDR: rd_word = {{(32 - IRQ_W){1'b0}}, stat_r};
      IRQ_MASK_ADDR: rd_word = {{(32 - IRQ_W){1'b0}}, mask_r};
      STATUS_ADDR: rd_word = {8'h00, st_r, count};
      // command register is write-only and reads as zero
      default: rd_word = BAD_ADDR_DATA;
    endcase
    prdata_nxt = rd ? rd_word : prdata_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // handshake: one pready pulse per transfer, error only on unmapped words
  always_comb begin
    pready_nxt = access;
    pslverr_nxt = access && !hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // the nmi pulse ignores the mask
  always_comb begin
    nmi_nxt = ovf;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_r <= 1'b0;
    end else begin
      nmi_r <= nmi_nxt;
    end
  end

  // summary irq follows the next status so it rises with the sticky bit
  always_comb begin
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign watchdog_overflow_irq = nmi_r;
  // request to the chip reset logic only; the reset pin is never driven
  assign internal_reset_req = rstreq_r;
  assign irq = irq_r;
endmodule : rwdt_runaway_watchdog

// ===== rwdt_props.sv
`timescale 1ns/1ps
module rwdt_props
  import rwdt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rwdt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic watchdog_overflow_irq,
  input wire logic internal_reset_req
);
  logic [15:0] up_r, up_nxt;
  logic [4:0] hi_r, hi_nxt;
  logic mapped;
  // saturate so long runs never wrap back into the early window
  always_comb begin
    up_nxt = (up_r == 16'hFFFF) ? up_r : up_r + 16'h1;
    hi_nxt = internal_reset_req ? hi_r + 5'h1 : 5'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_r <= 16'h0;
      hi_r <= 5'h0;
    end else begin
      up_r <= up_nxt;
      hi_r <= hi_nxt;
    end
  end
  assign mapped = paddr inside {MODE_ADDR, CMD_ADDR, IRQ_STAT_ADDR, IRQ_MASK_ADDR, STATUS_ADDR};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_bad_addr: assert property (pready |-> pslverr == !mapped) else $error("slverr");
  a_cmd_wo: assert property (pready && !pwrite && paddr == CMD_ADDR |-> prdata == 32'h0)
    else $error("cmd read");
  a_mode_resv: assert property (pready && !pwrite && paddr == MODE_ADDR
    |-> (prdata & ~32'(MODE_WMASK)) == 32'h0) else $error("mode bits");
  a_ovf_pulse: assert property (watchdog_overflow_irq |=> !watchdog_overflow_irq)
    else $error("ovf pulse");
  a_ovf_early: assert property (watchdog_overflow_irq |-> up_r >= 16'h7D00)
    else $error("early ovf");
  a_rst_len: assert property ($fell(internal_reset_req) |-> hi_r == 5'h16)
    else $error("reset length");
  a_rst_cause: assert property ($rose(internal_reset_req) |-> watchdog_overflow_irq
    || $past(watchdog_overflow_irq) || $past(watchdog_overflow_irq, 2)) else $error("reset");
  c_ovf: cover property (watchdog_overflow_irq);
  c_rst: cover property ($fell(internal_reset_req));
  c_err: cover property (pslverr);
endmodule : rwdt_props
bind rwdt_runaway_watchdog rwdt_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .watchdog_overflow_irq, .internal_reset_req);

// ===== rwdt_core_model.sv
`timescale 1ns/1ps
module rwdt_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] lp_req,
  output logic idle_one_mode,
  output logic idle_two_mode,
  output logic stop_mode
);
  logic [2:0] lp_r, lp_nxt;
  // idle-2 requested whenever lp_req is 2, whatever the mode bit
  always_comb lp_nxt = {lp_req == 2'h3, lp_req == 2'h2, lp_req == 2'h1};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lp_r <= 3'h0;
    else lp_r <= lp_nxt;
  end
  assign {stop_mode, idle_two_mode, idle_one_mode} = lp_r;
endmodule : rwdt_core_model

// ===== rwdt_runaway_watchdog_test.sv
`timescale 1ns/1ps
module rwdt_runaway_watchdog_test;
  import rwdt_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, d;
  logic pready, pslverr, ovf, rst, irq, i1, i2, st;
  logic [1:0] lp_req = 2'h0;
  int miscompares = 0, n_checks = 0, c0, c1, i, k;
  rwdt_runaway_watchdog uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .idle_one_mode(i1), .idle_two_mode(i2), .stop_mode(st),
    .watchdog_overflow_irq(ovf), .internal_reset_req(rst), .irq);
  rwdt_core_model u_core (.pclk, .presetn, .lp_req, .idle_one_mode(i1), .idle_two_mode(i2),
    .stop_mode(st));
  initial forever #2.5 pclk = ~pclk;
  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 9 && pready !== 1'b1; k++) @(posedge pclk);
    if (k == 9) begin
      miscompares++;
      complete_run();
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdx(input logic [17:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask : rdx
  // counter must move (or not) over a fixed gap
  task automatic grow(input logic x);
    apb(1'b0, STATUS_ADDR, 32'h0);
    c0 = int'(rd[21:0]);
    repeat (8) @(posedge pclk);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(32'(int'(rd[21:0]) > c0), 32'(x));
  endtask : grow
  task automatic wovf();
    for (c0 = 0; c0 < 40000 && ovf !== 1'b1; c0++) @(posedge pclk);
    if (c0 == 40000) begin
      miscompares++;
      complete_run();
    end
  endtask : wovf
  function automatic logic [31:0] mode_exp(input logic [31:0] v);
    return v & 32'(MODE_WMASK);
  endfunction : mode_exp
  initial begin
    i = $urandom(11);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdx(MODE_ADDR, 32'h80);
    rdx(CMD_ADDR, 32'h0);
    apb(1'b0, 18'h0, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, IRQ_MASK_ADDR, 32'h0);
    apb(1'b1, CMD_ADDR, 32'(KEY_CLEAR));
    wovf();
    chk(32'(c0 > 32763 && c0 < 32773), 32'h1);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b1, IRQ_MASK_ADDR, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    rdx(IRQ_STAT_ADDR, 32'h1);
    for (i = 0; i < 4; i++) begin
      d = ($urandom & 32'h1F) | 32'h80 | 32'(i << 5);
      apb(1'b1, MODE_ADDR, d);
      rdx(MODE_ADDR, mode_exp(d));
    end
    apb(1'b1, MODE_ADDR, 32'h80);
    apb(1'b1, CMD_ADDR, 32'(KEY_CLEAR));
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(32'(rd[21:0] < 22'h10), 32'h1);
    c1 = int'(rd[21:0]);
    repeat (4) begin
      d = $urandom;
      if (d[7:0] inside {KEY_CLEAR, KEY_DISABLE}) d[0] = ~d[0];
      apb(1'b1, CMD_ADDR, d);
    end
    apb(1'b1, CMD_ADDR, 32'(KEY_DISABLE));
    // six transfers of four edges each: no write may have cleared or stopped it
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(32'(rd[21:0]), 32'(c1 + 24));
    grow(1'b1);
    apb(1'b1, MODE_ADDR, 32'h0);
    grow(1'b1);
    apb(1'b1, CMD_ADDR, 32'(KEY_DISABLE));
    grow(1'b0);
    apb(1'b1, MODE_ADDR, 32'h80);
    grow(1'b1);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, MODE_ADDR, (i == 3) ? 32'h84 : 32'h80);
      lp_req <= (i == 3) ? 2'h2 : 2'(i + 1);
      grow(i == 3);
    end
    lp_req <= 2'h0;
    apb(1'b1, MODE_ADDR, 32'h82);
    apb(1'b1, CMD_ADDR, 32'(KEY_CLEAR));
    wovf();
    c1 = int'(rst === 1'b1);
    repeat (40) begin
      @(posedge pclk);
      c1 += int'(rst === 1'b1);
    end
    chk(32'(c1), 32'h16);
    rdx(IRQ_STAT_ADDR, 32'h3);
    complete_run();
  end
endmodule : rwdt_runaway_watchdog_test
